// ---- design/acr_config_regs.sv ----
// Purpose: configuration register bank with the output format, test word and offset loop path
// Assumes: i_wr is a completed serial write; i_sample is the core's offset-binary sample
// Notes:   all outputs registered; controls follow a write by one clock
`timescale 1ns/100ps
module acr_config_regs
(
  // clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_reset,
  // register port from the serial front end
  input  wire acr_pkg::acr_wr_type      i_wr,
  input  wire logic [7:0]               i_rd_addr,
  output logic      [7:0]               o_rd_data,
  // straps and neighbouring controls
  input  wire logic [1:0]               i_format_select_pin,
  input  wire logic [2:0]               i_pattern_select,
  input  wire logic [5:0]               i_swing_code,
  // converter samples
  input  wire logic [13:0]              i_sample,
  // output data
  output logic      [13:0]              o_data_14,
  output logic      [11:0]              o_data_12,
  output logic                          o_data_oe,
  // output interface and clock controls
  output logic                          o_if_ddr,
  output logic                          o_twos_complement,
  output acr_pkg::acr_clk_ctrl_type     o_clk_ctrl,
  output logic                          o_swing_override,
  output logic      [5:0]               o_swing_code,
  output logic                          o_high_freq_boost,
  // power and digital path state
  output acr_pkg::acr_power_type        o_power,
  output logic                          o_low_latency,
  output logic                          o_loop_running,
  output logic      [14:0]              o_offset_estimate
);
  import acr_pkg::*;

  logic [7:0] regs_q [NUM_REGS];

  function automatic logic [1:0] fld2(input logic [7:0] r, input int pos);
    fld2 = r[pos +: 2];
  endfunction

  // register bank: masked store, reserved bits never held
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++)
    begin : g_reg
      always_ff @(posedge i_core_clk)
      begin
        if (i_reset)
          regs_q[gi] <= REG_RESET;
        else if (i_wr.en && i_wr.addr == REG_ADDR[gi])
          regs_q[gi] <= i_wr.data & REG_MASK[gi];
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      o_rd_data <= 8'h00;
    else
    begin
      o_rd_data <= 8'h00;
      for (int k = 0; k < NUM_REGS; k++)
        if (i_rd_addr == REG_ADDR[k])
          o_rd_data <= regs_q[k];
    end
  end

  // field views
  logic [1:0]  format_code;
  logic        loop_on;
  logic [13:0] user_word;
  logic [1:0]  if_sel;
  logic        rise_on;
  logic        fall_on;
  logic [1:0]  rise_shift;
  logic [1:0]  fall_shift;
  logic        digital_on;
  logic        sleep;
  logic        shutdown;
  logic        driver_off;
  logic [1:0]  swing_ovr;
  logic [5:0]  pedestal;
  logic        hold;
  logic [3:0]  span;

  assign format_code = fld2(regs_q[IDX_FORMAT], POS_FORMAT);
  assign loop_on     = regs_q[IDX_FORMAT][POS_LOOP_ON];
  assign user_word   = {regs_q[IDX_WORD_HIGH], regs_q[IDX_WORD_LOW][7:POS_WORD_LOW]};
  assign if_sel      = fld2(regs_q[IDX_IF_RISE], POS_IF_SEL);
  assign rise_on     = regs_q[IDX_IF_RISE][POS_RISE_ON];
  assign rise_shift  = fld2(regs_q[IDX_IF_RISE], POS_RISE_SHIFT);
  assign fall_on     = regs_q[IDX_IF_RISE][POS_FALL_ON];
  assign fall_shift  = fld2(regs_q[IDX_FALL_QUICK_SLEEP], POS_FALL_SHIFT);
  assign digital_on  = regs_q[IDX_FALL_QUICK_SLEEP][POS_DIGITAL_ON];
  assign sleep       = regs_q[IDX_FALL_QUICK_SLEEP][POS_SLEEP];
  assign shutdown    = regs_q[IDX_PDN_SWING][POS_SHUTDOWN];
  assign driver_off  = regs_q[IDX_PDN_SWING][POS_DRIVER_OFF];
  assign swing_ovr   = fld2(regs_q[IDX_PDN_SWING], POS_SWING_OVR);
  assign pedestal    = regs_q[IDX_PEDESTAL][7:POS_PEDESTAL];
  assign hold        = regs_q[IDX_LOOP_CTRL][POS_HOLD];
  assign span        = regs_q[IDX_LOOP_CTRL][5:POS_SPAN];

  // interface and format decode
  logic ddr_d;
  logic twos_d;

  always_comb
  begin
    unique case (if_sel)
      IF_DDR:      ddr_d = 1'b1;
      IF_PARALLEL: ddr_d = 1'b0;
      default:     ddr_d = i_format_select_pin[1];
    endcase
    unique case (format_code)
      FMT_TWOS:       twos_d = 1'b1;
      FMT_OFFSET_BIN: twos_d = 1'b0;
      default:        twos_d = i_format_select_pin[0];
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_if_ddr          <= 1'b0;
      o_twos_complement <= 1'b0;
    end
    else
    begin
      o_if_ddr          <= ddr_d;
      o_twos_complement <= twos_d;
    end
  end

  // output clock edge placement
  logic [1:0] rise_eff;
  logic [1:0] fall_eff;
  acr_clk_ctrl_type clk_d;

  always_comb
  begin
    rise_eff = rise_on ? rise_shift : 2'h0;
    fall_eff = fall_on ? fall_shift : 2'h0;
    clk_d.clk_drive = fld2(regs_q[IDX_IF_RISE], POS_CLK_DRIVE);
    if (ddr_d)
    begin
      clk_d.rise_cut_ps  = DDR_RISE_CUT_PS[rise_eff];
      clk_d.rise_aligned = (rise_eff == DDR_ALIGN_CODE);
      clk_d.fall_cut_ps  = DDR_FALL_CUT_PS[fall_eff];
      clk_d.fall_aligned = (fall_eff == DDR_ALIGN_CODE);
    end
    else
    begin
      clk_d.rise_cut_ps  = PAR_CUT_PS[rise_eff];
      clk_d.rise_aligned = 1'b0;
      clk_d.fall_cut_ps  = PAR_CUT_PS[fall_eff];
      clk_d.fall_aligned = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      o_clk_ctrl <= '0;
    else
      o_clk_ctrl <= clk_d;
  end

  // power, swing and performance controls
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_power           <= '0;
      o_data_oe         <= 1'b0;
      o_swing_override  <= 1'b0;
      o_swing_code      <= 6'h00;
      o_high_freq_boost <= 1'b0;
      o_low_latency     <= 1'b1;
    end
    else
    begin
      o_power.core_pd   <= sleep | shutdown;
      o_power.ref_pd    <= shutdown;
      o_power.obuf_pd   <= sleep | shutdown | driver_off;
      o_power.pins_hiz  <= driver_off;
      o_data_oe         <= !(sleep | shutdown | driver_off);
      o_swing_override  <= (swing_ovr == SWING_ON);
      o_swing_code      <= (swing_ovr == SWING_ON) ? i_swing_code : 6'h00;
      o_high_freq_boost <= regs_q[IDX_HIGH_FREQ][POS_BOOST];
      o_low_latency     <= !digital_on;
    end
  end

  // offset correction loop: first-order, estimate = acc / 2^(20+span)
  logic                    loop_run;
  logic signed [ACC_W-1:0] acc_q;
  logic signed [15:0]      est;
  logic signed [15:0]      corrected;
  logic signed [15:0]      target;
  logic signed [15:0]      err;
  logic [4:0]              shift_amt;
  logic [13:0]             corr_clip;

  assign loop_run  = loop_on && digital_on;
  // codes beyond the table saturate at the longest span
  assign shift_amt = 5'(SPAN_BASE_LOG2) + {1'b0, (span > SPAN_MAX_CODE) ? SPAN_MAX_CODE : span};
  assign est       = 16'(acc_q >>> shift_amt);
  assign corrected = $signed({2'b00, i_sample}) - est;
  assign target    = $signed({1'b0, MID_CODE}) + 16'(signed'(pedestal));
  assign err       = corrected - target;

  always_comb
  begin
    if (corrected < 0)
      corr_clip = 14'h0000;
    else if (corrected > 16'sh3FFF)
      corr_clip = 14'h3FFF;
    else
      corr_clip = corrected[13:0];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      acc_q <= '0;
    else if (loop_run && !hold)
      acc_q <= acc_q + ACC_W'(err);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_loop_running    <= 1'b0;
      o_offset_estimate <= 15'h0000;
    end
    else
    begin
      o_loop_running    <= loop_run && !hold;
      o_offset_estimate <= loop_run ? est[14:0] : 15'h0000;
    end
  end

  // output data: user word, corrected or raw sample, then number format
  logic [13:0] word_sel;
  logic [13:0] word_out;

  always_comb
  begin
    if (digital_on && i_pattern_select == PAT_USER_WORD)
      word_sel = user_word;
    else if (loop_run)
      word_sel = corr_clip;
    else
      word_sel = i_sample;
    word_out = word_sel;
    // the user word is sent as written, not reformatted
    if (twos_d && !(digital_on && i_pattern_select == PAT_USER_WORD))
      word_out[13] = ~word_sel[13];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_data_14 <= 14'h0000;
      o_data_12 <= 12'h000;
    end
    else
    begin
      o_data_14 <= word_out;
      o_data_12 <= word_out[13:2];
    end
  end

  // checks
  property p_rise_gated;
    @(posedge i_core_clk) disable iff (i_reset)
    !rise_on |=> (o_clk_ctrl.rise_cut_ps == 11'h000 && !o_clk_ctrl.rise_aligned);
  endproperty
  a_rise_gated: assert property (p_rise_gated) else $error("rise edge moved while disabled");

  property p_fall_gated;
    @(posedge i_core_clk) disable iff (i_reset)
    !fall_on |=> (o_clk_ctrl.fall_cut_ps == 11'h000 && !o_clk_ctrl.fall_aligned);
  endproperty
  a_fall_gated: assert property (p_fall_gated) else $error("fall edge moved while disabled");

  property p_par_rise_max;
    @(posedge i_core_clk) disable iff (i_reset)
    (rise_on && rise_shift == 2'h3 && if_sel == IF_PARALLEL) |=> o_clk_ctrl.rise_cut_ps == 11'h5DC;
  endproperty
  a_par_rise_max: assert property (p_par_rise_max) else $error("parallel rise not 1.5ns");

  property p_ddr_rise;
    @(posedge i_core_clk) disable iff (i_reset)
    (rise_on && rise_shift == 2'h1 && if_sel == IF_DDR) |=> o_clk_ctrl.rise_cut_ps == 11'h1F4;
  endproperty
  a_ddr_rise: assert property (p_ddr_rise) else $error("ddr rise not 500ps");

  property p_write_effect;
    @(posedge i_core_clk) disable iff (i_reset)
    (i_wr.en && i_wr.addr == ADDR_FALL_QUICK_SLEEP) ##1 1'b1 |=> o_low_latency == !$past(i_wr.data[3], 2);
  endproperty
  a_write_effect: assert property (p_write_effect) else $error("latency not after write");

  property p_hiz;
    @(posedge i_core_clk) disable iff (i_reset)
    driver_off |=> (o_power.pins_hiz && !o_data_oe);
  endproperty
  a_hiz: assert property (p_hiz) else $error("pins driven while driver off");

  property p_sleep_ref;
    @(posedge i_core_clk) disable iff (i_reset)
    (sleep && !shutdown) |=> (o_power.core_pd && !o_power.ref_pd);
  endproperty
  a_sleep_ref: assert property (p_sleep_ref) else $error("sleep changed reference");

  property p_swing;
    @(posedge i_core_clk) disable iff (i_reset)
    (swing_ovr != SWING_ON) |=> (!o_swing_override && o_swing_code == 6'h00);
  endproperty
  a_swing: assert property (p_swing) else $error("swing override without code 11");

  property p_hold;
    @(posedge i_core_clk) disable iff (i_reset)
    (loop_run && hold) [*2] |-> $stable(acc_q);
  endproperty
  a_hold: assert property (p_hold) else $error("estimate moved while held");

  property p_loop_off;
    @(posedge i_core_clk) disable iff (i_reset)
    !loop_run |=> (o_offset_estimate == 15'h0000 && !o_loop_running);
  endproperty
  a_loop_off: assert property (p_loop_off) else $error("loop active while disabled");

  property p_user_word;
    @(posedge i_core_clk) disable iff (i_reset)
    (digital_on && i_pattern_select == PAT_USER_WORD) |=> o_data_12 == $past(user_word[13:2]);
  endproperty
  a_user_word: assert property (p_user_word) else $error("user word not on output");

  property p_shutdown;
    @(posedge i_core_clk) disable iff (i_reset)
    shutdown |=> (o_power.core_pd && o_power.ref_pd && o_power.obuf_pd && !o_data_oe);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("block powered in shutdown");

  property p_twos_code;
    @(posedge i_core_clk) disable iff (i_reset)
    (format_code == FMT_TWOS) |=> o_twos_complement;
  endproperty
  a_twos_code: assert property (p_twos_code) else $error("format code 10 not twos");

  property p_offset_bin_code;
    @(posedge i_core_clk) disable iff (i_reset)
    (format_code == FMT_OFFSET_BIN) |=> !o_twos_complement;
  endproperty
  a_offset_bin_code: assert property (p_offset_bin_code) else $error("code 11 not offset binary");

  property p_ddr_code;
    @(posedge i_core_clk) disable iff (i_reset)
    (if_sel == IF_DDR) |=> o_if_ddr;
  endproperty
  a_ddr_code: assert property (p_ddr_code) else $error("interface code 01 not ddr");

  property p_par_code;
    @(posedge i_core_clk) disable iff (i_reset)
    (if_sel == IF_PARALLEL) |=> !o_if_ddr;
  endproperty
  a_par_code: assert property (p_par_code) else $error("interface code 11 not parallel");

  property p_ddr_fall_align;
    @(posedge i_core_clk) disable iff (i_reset)
    (fall_on && fall_shift == DDR_ALIGN_CODE && if_sel == IF_DDR) |=>
      (o_clk_ctrl.fall_aligned && o_clk_ctrl.fall_cut_ps == 11'h000);
  endproperty
  a_ddr_fall_align: assert property (p_ddr_fall_align) else $error("ddr fall not aligned");

endmodule

// ---- design/acr_pkg.sv ----
// Purpose: constants and types for the converter output and digital configuration registers
// Assumes: an 8-bit address, 8-bit data register port fed by the serial configuration front end
// Notes:   every register resets to 00h
package acr_pkg;

  localparam int NUM_REGS = 9;

  localparam logic [7:0] ADDR_FORMAT     = 8'h3D;
  localparam logic [7:0] ADDR_WORD_HIGH  = 8'h3F;
  localparam logic [7:0] ADDR_WORD_LOW   = 8'h40;
  localparam logic [7:0] ADDR_IF_RISE    = 8'h41;
  localparam logic [7:0] ADDR_FALL_QUICK_SLEEP  = 8'h42;
  localparam logic [7:0] ADDR_PDN_SWING  = 8'h43;
  localparam logic [7:0] ADDR_HIGH_FREQ  = 8'h4A;
  localparam logic [7:0] ADDR_PEDESTAL   = 8'hBF;
  localparam logic [7:0] ADDR_LOOP_CTRL  = 8'hCF;

  localparam int IDX_FORMAT    = 0;
  localparam int IDX_WORD_HIGH = 1;
  localparam int IDX_WORD_LOW  = 2;
  localparam int IDX_IF_RISE   = 3;
  localparam int IDX_FALL_QUICK_SLEEP = 4;
  localparam int IDX_PDN_SWING = 5;
  localparam int IDX_HIGH_FREQ = 6;
  localparam int IDX_PEDESTAL  = 7;
  localparam int IDX_LOOP_CTRL = 8;

  localparam logic [7:0] REG_ADDR [NUM_REGS] = '{ADDR_FORMAT, ADDR_WORD_HIGH, ADDR_WORD_LOW,
    ADDR_IF_RISE, ADDR_FALL_QUICK_SLEEP, ADDR_PDN_SWING, ADDR_HIGH_FREQ, ADDR_PEDESTAL, ADDR_LOOP_CTRL};
  // writable bits; reserved positions are not stored and read back zero
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{8'hE0, 8'hFF, 8'hFC,
    8'hFF, 8'hCC, 8'h53, 8'h01, 8'hFC, 8'hBC};
  localparam logic [7:0] REG_RESET = 8'h00;

  // field positions
  localparam int POS_FORMAT      = 6;
  localparam int POS_LOOP_ON     = 5;
  localparam int POS_WORD_LOW    = 2;
  localparam int POS_IF_SEL      = 6;
  localparam int POS_CLK_DRIVE   = 4;
  localparam int POS_RISE_ON     = 3;
  localparam int POS_RISE_SHIFT  = 1;
  localparam int POS_FALL_ON     = 0;
  localparam int POS_FALL_SHIFT  = 6;
  localparam int POS_DIGITAL_ON  = 3;
  localparam int POS_SLEEP       = 2;
  localparam int POS_SHUTDOWN    = 6;
  localparam int POS_DRIVER_OFF  = 4;
  localparam int POS_SWING_OVR   = 0;
  localparam int POS_BOOST       = 0;
  localparam int POS_PEDESTAL    = 2;
  localparam int POS_HOLD        = 7;
  localparam int POS_SPAN        = 2;

  // field codes
  localparam logic [1:0] FMT_TWOS       = 2'h2;
  localparam logic [1:0] FMT_OFFSET_BIN = 2'h3;
  localparam logic [1:0] IF_DDR         = 2'h1;
  localparam logic [1:0] IF_PARALLEL    = 2'h3;
  localparam logic [1:0] SWING_ON       = 2'h3;
  localparam logic [2:0] PAT_USER_WORD  = 3'h5;

  // edge shifts in picoseconds
  localparam logic [10:0] DDR_RISE_CUT_PS [4] = '{11'h000, 11'h1F4, 11'h000, 11'h0C8};
  localparam logic [10:0] DDR_FALL_CUT_PS [4] = '{11'h000, 11'h190, 11'h000, 11'h0C8};
  localparam logic [10:0] PAR_CUT_PS      [4] = '{11'h000, 11'h064, 11'h0C8, 11'h5DC};
  localparam logic [1:0]  DDR_ALIGN_CODE = 2'h2;

  // loop span: code 0 is 2^20 cycles, code 11 is 2^31
  localparam int          SPAN_BASE_LOG2 = 20;
  localparam logic [3:0]  SPAN_MAX_CODE  = 4'hB;
  localparam logic [14:0] MID_CODE       = 15'h2000;
  localparam int          ACC_W          = 48;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } acr_wr_type;

  typedef struct packed {
    logic [10:0] rise_cut_ps;
    logic        rise_aligned;
    logic [10:0] fall_cut_ps;
    logic        fall_aligned;
    logic [1:0]  clk_drive;
  } acr_clk_ctrl_type;

  typedef struct packed {
    logic core_pd;
    logic ref_pd;
    logic obuf_pd;
    logic pins_hiz;
  } acr_power_type;

endpackage

// ---- verification/acr_host_model.sv ----
// Purpose: host model that writes and reads back the configuration registers
// Assumes: one completed serial write is a one-clock strobe on the register port
// Notes:   reserved bits and illegal swing codes are cleared unless raw is asked for
`timescale 1ns/100ps
module acr_host_model
(
  // clock
  input  wire logic                i_core_clk,
  // register port
  output acr_pkg::acr_wr_type      o_wr,
  output logic      [7:0]          o_rd_addr,
  input  wire logic [7:0]          i_rd_data
);
  import acr_pkg::*;

  initial
  begin
    o_wr = '0;
    o_rd_addr = 8'h00;
  end

  task automatic host_write(input logic [7:0] a, input logic [7:0] d, input bit raw = 1'h0);
    logic [7:0] v;
    v = d;
    if (!raw)
    begin
      for (int k = 0; k < NUM_REGS; k++)
        if (REG_ADDR[k] == a)
          v = v & REG_MASK[k];
      if (a == ADDR_PDN_SWING && (v[1] ^ v[0]))
        v[1:0] = 2'h0;
    end
    @(posedge i_core_clk);
    #1;
    o_wr = '{en: 1'h1, addr: a, data: v};
    @(posedge i_core_clk);
    #1;
    // released data no longer shows the written value
    o_wr.en = 1'h0;
    o_wr.data = ~v;
    // decoded controls land one clock after the register
    @(posedge i_core_clk);
    @(posedge i_core_clk);
    #1;
  endtask

  task automatic host_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    #1;
    o_rd_addr = a;
    @(posedge i_core_clk);
    @(posedge i_core_clk);
    #1;
    d = i_rd_data;
  endtask
endmodule

// ---- verification/acr_config_regs_tb_top.sv ----
// Purpose: self-checking bench for the configuration register bank
// Assumes: host model drives the register port 1ns after a rising clock edge
// Notes:   loop convergence and span timing are not covered; they need millions of cycles
`timescale 1ns/100ps
module acr_config_regs_tb_top;
  import acr_pkg::*;
  logic             i_core_clk = 1'h0;
  logic             i_reset = 1'h1;
  acr_wr_type       wr;
  logic [7:0]       rd_addr;
  logic [7:0]       rd_data;
  logic [1:0]       fmt_pin = 2'h0;
  logic [2:0]       pat_sel = 3'h5;
  logic [5:0]       swing = 6'h00;
  logic [13:0]      sample = 14'h1234;
  logic [13:0]      d14;
  logic [11:0]      d12;
  logic             oe, ddr, twos, swing_ovr, boost, low_lat, loop_run;
  logic [5:0]       swing_out;
  logic [14:0]      est;
  acr_clk_ctrl_type clk_ctrl;
  acr_power_type    pwr;
  int               n_errors = 0;
  int               num_checks = 0;
  int               cycles = 0;
  // {raw, address, written, read back}
  localparam logic [24:0] ROWS [12] = '{25'h03DE0E0, 25'h03FA5A5, 25'h0405C5C,
    25'h0419696, 25'h042C8C8, 25'h0435050, 25'h04A0101, 25'h0BF8484, 25'h0CFBCBC,
    25'h142FFCC, 25'h150FF00, 25'h14AFF01};
  // {format code, interface code, pin, twos, ddr}
  localparam logic [7:0] DEC [4] = '{8'h00, 8'h2F, 8'h93, 8'hFC};

  always #10 i_core_clk = ~i_core_clk;

  acr_host_model acr_host_model_i (.i_core_clk(i_core_clk), .o_wr(wr), .o_rd_addr(rd_addr),
    .i_rd_data(rd_data));

  acr_config_regs acr_config_regs_i (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_wr(wr), .i_rd_addr(rd_addr), .o_rd_data(rd_data), .i_format_select_pin(fmt_pin),
    .i_pattern_select(pat_sel), .i_swing_code(swing), .i_sample(sample),
    .o_data_14(d14), .o_data_12(d12), .o_data_oe(oe), .o_if_ddr(ddr),
    .o_twos_complement(twos), .o_clk_ctrl(clk_ctrl), .o_swing_override(swing_ovr),
    .o_swing_code(swing_out), .o_high_freq_boost(boost), .o_power(pwr),
    .o_low_latency(low_lat), .o_loop_running(loop_run), .o_offset_estimate(est));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input bit raw = 1'h0);
    acr_host_model_i.host_write(a, d, raw);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    acr_host_model_i.host_read(a, v);
    check($sformatf("reg %h", a), v, exp);
  endtask

  task automatic reset_all();
    foreach (ROWS[k])
      rd_chk(ROWS[k][23:16], 8'h00);
    check("low_latency", low_lat, 1'h1);
  endtask

  // a hang ends the run as a mismatch
  always @(posedge i_core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      end_sim();
    end
  end

  initial
  begin
    repeat (4) @(posedge i_core_clk);
    #1;
    i_reset = 1'h0;
    reset_all();
    $display("test reset values done");
    foreach (ROWS[k])
    begin
      wr_reg(ROWS[k][23:16], ROWS[k][15:8], ROWS[k][24]);
      rd_chk(ROWS[k][23:16], ROWS[k][7:0]);
    end
    $display("test register table done");
    @(posedge i_core_clk);
    #1;
    i_reset = 1'h1;
    repeat (4) @(posedge i_core_clk);
    #1;
    i_reset = 1'h0;
    reset_all();
    $display("test mid-run reset done");
    foreach (DEC[k])
    begin
      fmt_pin = DEC[k][3:2];
      wr_reg(ADDR_FORMAT, {DEC[k][7:6], 6'h00});
      wr_reg(ADDR_IF_RISE, {DEC[k][5:4], 6'h00});
      check("twos", twos, DEC[k][1]);
      check("ddr", ddr, DEC[k][0]);
      check("raw data", d14, {DEC[k][1], 13'h1234});
    end
    $display("test format decode done");
    wr_reg(ADDR_WORD_HIGH, 8'hA5);
    wr_reg(ADDR_WORD_LOW, 8'h5C);
    check("bypass data", d14, 14'h1234);
    wr_reg(ADDR_FALL_QUICK_SLEEP, 8'h08);
    check("low_latency", low_lat, 1'h0);
    check("word 14", d14, 14'h2957);
    check("word 12", d12, 12'hA55);
    $display("test user word done");
    wr_reg(ADDR_IF_RISE, 8'h5B);
    wr_reg(ADDR_FALL_QUICK_SLEEP, 8'h48);
    check("ddr rise", clk_ctrl.rise_cut_ps, 11'h1F4);
    check("ddr fall", clk_ctrl.fall_cut_ps, 11'h190);
    check("drive", clk_ctrl.clk_drive, 2'h1);
    wr_reg(ADDR_IF_RISE, 8'h5D);
    check("rise aligned", clk_ctrl.rise_aligned, 1'h1);
    wr_reg(ADDR_FALL_QUICK_SLEEP, 8'h88);
    check("fall aligned", clk_ctrl.fall_aligned, 1'h1);
    wr_reg(ADDR_IF_RISE, 8'hFF);
    wr_reg(ADDR_FALL_QUICK_SLEEP, 8'hC8);
    check("par rise", clk_ctrl.rise_cut_ps, 11'h5DC);
    check("par fall", clk_ctrl.fall_cut_ps, 11'h5DC);
    wr_reg(ADDR_IF_RISE, 8'hF6);
    check("rise off", clk_ctrl.rise_cut_ps, 11'h000);
    check("fall off", clk_ctrl.fall_cut_ps, 11'h000);
    $display("test clock edges done");
    wr_reg(ADDR_FALL_QUICK_SLEEP, 8'h04);
    check("sleep", pwr, 4'hA);
    check("sleep oe", oe, 1'h0);
    wr_reg(ADDR_FALL_QUICK_SLEEP, 8'h00);
    wr_reg(ADDR_PDN_SWING, 8'h40);
    check("shutdown", pwr[3:1], 3'h7);
    wr_reg(ADDR_PDN_SWING, 8'h10);
    check("driver off", pwr, 4'h3);
    check("driver off oe", oe, 1'h0);
    wr_reg(ADDR_PDN_SWING, 8'h00);
    check("driver on oe", oe, 1'h1);
    $display("test power done");
    swing = 6'h2A;
    wr_reg(ADDR_PDN_SWING, 8'h03);
    check("swing on", {swing_ovr, swing_out}, 7'h6A);
    wr_reg(ADDR_PDN_SWING, 8'h00);
    check("swing off", {swing_ovr, swing_out}, 7'h00);
    wr_reg(ADDR_HIGH_FREQ, 8'h01);
    check("boost", boost, 1'h1);
    $display("test swing and boost done");
    wr_reg(ADDR_FALL_QUICK_SLEEP, 8'h08);
    wr_reg(ADDR_FORMAT, 8'h20);
    check("loop on", loop_run, 1'h1);
    wr_reg(ADDR_LOOP_CTRL, 8'h80);
    check("loop held", loop_run, 1'h0);
    wr_reg(ADDR_LOOP_CTRL, 8'h00);
    wr_reg(ADDR_FORMAT, 8'h00);
    check("loop off", loop_run, 1'h0);
    check("estimate off", est, 15'h0000);
    $display("test offset loop done");
    end_sim();
  end
endmodule
